// >>> rtl/regfile_pkg.sv
// constants and types shared by the core register file
// Function
// - thirty-two integer registers, 64 or 32 bits wide by implementation
// - any integer register readable as source and writable as destination
// - thirty-two 64-bit float registers used as floating-point operands
// - float register contents are always read as double precision
// - float arithmetic writes a float register, except compares, which write none
// - float status goes to the status register, optionally also to condition field
// - single-precision results are rounded, then stored in double format
// - summary overflow set whenever overflow sets; cleared only by register move or move to condition field
// - instructions that cannot overflow leave summary overflow unchanged
// - register write of summary zero, overflow one gives exactly that
// - add, subtract, negate: overflow is carry-out of msb xor next bit
// - multiply-low, divide: overflow when result misfits 64 or 32 bits
// - instructions that cannot overflow leave overflow flag unchanged
// - carrying and extended adds set carry from msb carry-out
// - shift right algebraic: carry when negative and a one shifted out
// - other instructions leave carry unchanged, save shift, register write, move
// - low seven bits hold the string instruction byte count
// - float exception bits except two summaries stay set until explicitly cleared
package regfile_pkg;

  localparam int NUM_REGS = 32;
  localparam int ADDR_W   = 5;
  localparam int FP_W     = 64;
  localparam int EXC_W    = 32;
  localparam int FSC_W    = 32;
  localparam int COND_W   = 4;

  // bit 0 of the big-endian numbering is bit 31 here
  localparam int EXC_SO      = 31;
  localparam int EXC_OVF     = 30;
  localparam int EXC_CRY     = 29;
  localparam int EXC_BC_W    = 7;
  localparam logic [EXC_W-1:0] EXC_IMPL_MASK = 32'he000007f;
  localparam logic [EXC_W-1:0] EXC_MOVE_MASK = 32'hf0000000;
  localparam logic [EXC_W-1:0] EXC_RESET     = 32'h00000000;

  localparam int FSC_SUM_ANY = 31;
  localparam int FSC_SUM_EN  = 30;
  localparam int FSC_SUM_INV = 29;
  localparam int FSC_OX      = 28;
  localparam int FSC_UX      = 27;
  localparam int FSC_ZX      = 26;
  localparam int FSC_XX      = 25;
  localparam int FSC_VE      = 7;
  localparam int FSC_OE      = 6;
  localparam int FSC_UE      = 5;
  localparam int FSC_ZE      = 4;
  localparam int FSC_XE      = 3;
  localparam logic [FSC_W-1:0] FSC_STICKY_MASK = 32'h9ff80700;
  localparam logic [FSC_W-1:0] FSC_EXC_MASK    = 32'h1ff80700;
  localparam logic [FSC_W-1:0] FSC_INV_MASK    = 32'h01f80700;
  localparam logic [FSC_W-1:0] FSC_RESULT_MASK = 32'h0007f800;
  localparam logic [FSC_W-1:0] FSC_SUM_MASK    = 32'h60000000;
  localparam logic [FSC_W-1:0] FSC_RESET       = 32'h00000000;

  // double format: fraction bits dropped when rounding to single
  localparam int DP_DROP   = 29;
  localparam int DP_EXP_HI = 62;
  localparam int DP_EXP_LO = 52;

  typedef enum logic [1:0] {
    OVF_NONE   = 2'b00,
    OVF_ADDSUB = 2'b01,
    OVF_MULDIV = 2'b10
  } ovf_kind_e;

  typedef enum logic [1:0] {
    CRY_NONE  = 2'b00,
    CRY_CARRY = 2'b01,
    CRY_SHIFT = 2'b10
  } cry_kind_e;

endpackage : regfile_pkg

// >>> rtl/regfile_mem.sv
// two-read one-write register array with registered read data
`timescale 1ns/100ps
module regfile_mem
  import regfile_pkg::*;
#(
  parameter int W     = 64,
  parameter int DEPTH = NUM_REGS,
  parameter int AW    = ADDR_W
) (
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  input  wire logic [AW-1:0] rdAddrA,
  input  wire logic [AW-1:0] rdAddrB,
  output logic      [W-1:0]  rdDataA,
  output logic      [W-1:0]  rdDataB,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData
);

  if (DEPTH != (1 << AW)) begin : g_chk
    $error("DEPTH must equal 2**AW");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rdA;
    logic [W-1:0]            rdB;
  } mem_s;

  mem_s s_q;
  mem_s s_d;

  // bypass so a result can be read back the cycle it is written
  always_comb begin
    s_d = s_q;
    s_d.rdA = (wrEn && wrAddr == rdAddrA) ? wrData : s_q.mem[rdAddrA];
    s_d.rdB = (wrEn && wrAddr == rdAddrB) ? wrData : s_q.mem[rdAddrB];
    if (wrEn) begin
      s_d.mem[wrAddr] = wrData;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdDataA = s_q.rdA;
  assign rdDataB = s_q.rdB;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_WRITE_READBACK: assert property (wrEn && rdAddrB == wrAddr |=> rdDataB == $past(wrData))
    else $error("written value not read back");
  AST_WRITE_HOLDS: assert property (wrEn ##1 (!wrEn && rdAddrA == $past(wrAddr))
      |=> rdDataA == $past(wrData, 2))
    else $error("register lost its written value");

endmodule : regfile_mem

// >>> rtl/cpu_register_file.sv
// integer and float register arrays with exception, count and status registers
`timescale 1ns/100ps
module cpu_register_file
  import regfile_pkg::*;
#(
  parameter int XLEN = 64
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] intRdAddrA,
  input  wire logic [ADDR_W-1:0] intRdAddrB,
  output logic      [XLEN-1:0]   intRdDataA,
  output logic      [XLEN-1:0]   intRdDataB,
  input  wire logic              intWrEn,
  input  wire logic [ADDR_W-1:0] intWrAddr,
  input  wire logic [XLEN-1:0]   intWrData,
  input  wire logic [ADDR_W-1:0] fpRdAddrA,
  input  wire logic [ADDR_W-1:0] fpRdAddrB,
  output logic      [FP_W-1:0]   fpRdDataA,
  output logic      [FP_W-1:0]   fpRdDataB,
  input  wire logic              fpWrEn,
  input  wire logic [ADDR_W-1:0] fpWrAddr,
  input  wire logic [FP_W-1:0]   fpWrData,
  input  wire logic              fpWrSingle,
  input  wire logic              fpIsCompare,
  input  wire ovf_kind_e         ovfKind,
  input  wire logic              carryOutMsb,
  input  wire logic              carryOutNext,
  input  wire logic              ovfWordForm,
  input  wire logic [2*XLEN-1:0] mulDivResult,
  input  wire cry_kind_e         cryKind,
  input  wire logic              shiftNeg,
  input  wire logic              shiftLostOne,
  input  wire logic              bcWrEn,
  input  wire logic [EXC_BC_W-1:0] bcValue,
  input  wire logic              sprWrEn,
  input  wire logic [EXC_W-1:0]  sprWrData,
  input  wire logic              movCondEn,
  output logic      [EXC_W-1:0]  excRdData,
  output logic      [EXC_BC_W-1:0] byteCount,
  output logic                   summaryOvf,
  output logic                   overflowFlag,
  output logic                   carryFlag,
  input  wire logic              fpStatusValid,
  input  wire logic [FSC_W-1:0]  fpStatusBits,
  input  wire logic              fpRecordCond,
  input  wire logic              fscWrEn,
  input  wire logic [FSC_W-1:0]  fscWrMask,
  input  wire logic [FSC_W-1:0]  fscWrData,
  output logic      [FSC_W-1:0]  fscRdData,
  output logic      [COND_W-1:0] condFieldOut,
  output logic                   condFieldValid
);

  if (XLEN != 32 && XLEN != 64) begin : g_chk
    $error("XLEN must be 32 or 64");
  end

  typedef struct packed {
    logic [EXC_W-1:0]  exc;
    logic [FSC_W-1:0]  fsc;
    logic [COND_W-1:0] cond;
    logic              condValid;
  } state_s;

  localparam state_s STATE_RESET = '{
    exc:       EXC_RESET,
    fsc:       FSC_RESET,
    cond:      '0,
    condValid: 1'b0
  };

  state_s s_q;
  state_s s_d;

  logic              ovfAddSub;
  logic              wordFits;
  logic              dwordFits;
  logic              ovfMulDiv;
  logic              roundUp;
  logic              expAllOnes;
  logic [FP_W-DP_DROP-2:0] magRounded;
  logic [FP_W-1:0]   fpRounded;
  logic              fpMemWrEn;
  logic [FSC_W-1:0]  fscMask;
  logic [FSC_W-1:0]  fscNewExc;

  // overflow sources
  assign ovfAddSub = carryOutMsb ^ carryOutNext;
  assign wordFits  = (&mulDivResult[2*XLEN-1:31]) | ~(|mulDivResult[2*XLEN-1:31]);
  assign dwordFits = (&mulDivResult[2*XLEN-1:XLEN-1]) | ~(|mulDivResult[2*XLEN-1:XLEN-1]);
  assign ovfMulDiv = ovfWordForm ? ~wordFits : ~dwordFits;

  // round to nearest even at single precision, kept in double layout;
  // a mantissa carry ripples into the exponent, which is the right answer
  assign expAllOnes = &fpWrData[DP_EXP_HI:DP_EXP_LO];
  assign roundUp    = fpWrData[DP_DROP-1]
                    & ((|fpWrData[DP_DROP-2:0]) | fpWrData[DP_DROP]);
  assign magRounded = fpWrData[FP_W-2:DP_DROP]
                    + {{(FP_W-DP_DROP-2){1'b0}}, roundUp};
  // infinities and nans are passed through untouched
  assign fpRounded  = (fpWrSingle && !expAllOnes)
                    ? {fpWrData[FP_W-1], magRounded, {DP_DROP{1'b0}}}
                    : fpWrData;
  assign fpMemWrEn  = fpWrEn & ~fpIsCompare;

  // enable and invalid summary bits are derived, never written directly
  assign fscMask    = fscWrMask & ~FSC_SUM_MASK;
  assign fscNewExc  = fpStatusBits & FSC_EXC_MASK;

  always_comb begin
    s_d = s_q;
    s_d.condValid = 1'b0;

    // explicit moves first, so a same-cycle hardware set wins
    if (sprWrEn) begin
      s_d.exc = sprWrData & EXC_IMPL_MASK;
    end else if (movCondEn) begin
      s_d.cond      = s_q.exc[EXC_SO -: COND_W];
      s_d.condValid = 1'b1;
      s_d.exc       = s_q.exc & ~EXC_MOVE_MASK;
    end

    unique case (ovfKind)
      OVF_NONE: begin
      end
      OVF_ADDSUB: begin
        s_d.exc[EXC_OVF] = ovfAddSub;
        if (ovfAddSub) begin
          s_d.exc[EXC_SO] = 1'b1;
        end
      end
      OVF_MULDIV: begin
        s_d.exc[EXC_OVF] = ovfMulDiv;
        if (ovfMulDiv) begin
          s_d.exc[EXC_SO] = 1'b1;
        end
      end
      default: begin
      end
    endcase

    unique case (cryKind)
      CRY_NONE: begin
      end
      CRY_CARRY: begin
        s_d.exc[EXC_CRY] = carryOutMsb;
      end
      CRY_SHIFT: begin
        s_d.exc[EXC_CRY] = shiftNeg & shiftLostOne;
      end
      default: begin
      end
    endcase

    if (bcWrEn) begin
      s_d.exc[EXC_BC_W-1:0] = bcValue;
    end

    // float status: explicit field write is the only way to clear a sticky bit
    if (fscWrEn) begin
      s_d.fsc = (s_q.fsc & ~fscMask) | (fscWrData & fscMask);
    end
    if (fpStatusValid) begin
      if (|(fscNewExc & ~s_d.fsc)) begin
        s_d.fsc[FSC_SUM_ANY] = 1'b1;
      end
      s_d.fsc = s_d.fsc | (fpStatusBits & FSC_STICKY_MASK);
      s_d.fsc = (s_d.fsc & ~FSC_RESULT_MASK)
              | (fpStatusBits & FSC_RESULT_MASK);
    end
    s_d.fsc[FSC_SUM_INV] = |(s_d.fsc & FSC_INV_MASK);
    s_d.fsc[FSC_SUM_EN]  = (s_d.fsc[FSC_SUM_INV] & s_d.fsc[FSC_VE])
                         | (s_d.fsc[FSC_OX] & s_d.fsc[FSC_OE])
                         | (s_d.fsc[FSC_UX] & s_d.fsc[FSC_UE])
                         | (s_d.fsc[FSC_ZX] & s_d.fsc[FSC_ZE])
                         | (s_d.fsc[FSC_XX] & s_d.fsc[FSC_XE]);

    // only one instruction completes a cycle; float record takes the field
    if (fpStatusValid && fpRecordCond) begin
      s_d.cond      = s_d.fsc[FSC_SUM_ANY -: COND_W];
      s_d.condValid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign excRdData      = s_q.exc;
  assign byteCount      = s_q.exc[EXC_BC_W-1:0];
  assign summaryOvf     = s_q.exc[EXC_SO];
  assign overflowFlag   = s_q.exc[EXC_OVF];
  assign carryFlag      = s_q.exc[EXC_CRY];
  assign fscRdData      = s_q.fsc;
  assign condFieldOut   = s_q.cond;
  assign condFieldValid = s_q.condValid;

  regfile_mem #(
    .W     (XLEN),
    .DEPTH (NUM_REGS),
    .AW    (ADDR_W)
  ) u_int_regs (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .rdAddrA (intRdAddrA),
    .rdAddrB (intRdAddrB),
    .rdDataA (intRdDataA),
    .rdDataB (intRdDataB),
    .wrEn    (intWrEn),
    .wrAddr  (intWrAddr),
    .wrData  (intWrData)
  );

  regfile_mem #(
    .W     (FP_W),
    .DEPTH (NUM_REGS),
    .AW    (ADDR_W)
  ) u_fp_regs (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .rdAddrA (fpRdAddrA),
    .rdAddrB (fpRdAddrB),
    .rdDataA (fpRdDataA),
    .rdDataB (fpRdDataB),
    .wrEn    (fpMemWrEn),
    .wrAddr  (fpWrAddr),
    .wrData  (fpRounded)
  );

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence sOvfSet;
    (ovfKind == OVF_ADDSUB && ovfAddSub) || (ovfKind == OVF_MULDIV && ovfMulDiv);
  endsequence

  sequence sNoExcMove;
    !sprWrEn && !movCondEn;
  endsequence

  sequence sMoveCond;
    movCondEn && !(fpStatusValid && fpRecordCond);
  endsequence

  sequence sFpRecord;
    fpStatusValid && fpRecordCond && !movCondEn;
  endsequence

  sequence sCmpOnHeldRead;
    !fpWrEn ##1 (fpWrEn && fpIsCompare && fpRdAddrA == fpWrAddr && $stable(fpRdAddrA));
  endsequence

  sequence sQuietArith;
    ovfKind == OVF_NONE && cryKind == CRY_NONE && !sprWrEn && !bcWrEn;
  endsequence

  property pFlagQuiet(logic quiet, logic flag);
    quiet |=> flag == $past(flag);
  endproperty

  AST_SO_SET: assert property (sOvfSet |=> summaryOvf && overflowFlag)
    else $error("summary overflow not set with overflow");
  AST_SO_STICKY: assert property (summaryOvf ##0 sNoExcMove |=> summaryOvf)
    else $error("summary overflow dropped without a move");
  AST_SO_QUIET: assert property (pFlagQuiet(
      ovfKind == OVF_NONE && !sprWrEn && !movCondEn, summaryOvf))
    else $error("summary overflow changed by a quiet instruction");
  AST_SPR_SO0_OV1: assert property (sprWrEn && !sprWrData[EXC_SO]
      && sprWrData[EXC_OVF] && ovfKind == OVF_NONE |=> !summaryOvf && overflowFlag)
    else $error("register write of summary 0 overflow 1 misapplied");
  AST_OVF_ADDSUB: assert property (ovfKind == OVF_ADDSUB
      |=> overflowFlag == $past(carryOutMsb ^ carryOutNext))
    else $error("add overflow does not match carries");
  AST_OVF_MULDIV: assert property (ovfKind == OVF_MULDIV && ovfWordForm
      |=> overflowFlag == !$past(wordFits))
    else $error("word multiply or divide overflow wrong");
  AST_OVF_QUIET: assert property (pFlagQuiet(
      ovfKind == OVF_NONE && !sprWrEn && !movCondEn, overflowFlag))
    else $error("overflow changed by a quiet instruction");
  AST_CRY_ADD: assert property (cryKind == CRY_CARRY |=> carryFlag == $past(carryOutMsb))
    else $error("carry does not follow msb carry-out");
  AST_CRY_SHIFT: assert property (cryKind == CRY_SHIFT
      |=> carryFlag == $past(shiftNeg && shiftLostOne))
    else $error("shift carry wrong");
  AST_CRY_QUIET: assert property (pFlagQuiet(
      cryKind == CRY_NONE && !sprWrEn && !movCondEn, carryFlag))
    else $error("carry changed by a non-carrying instruction");
  AST_BYTE_COUNT: assert property (bcWrEn |=> byteCount == $past(bcValue))
    else $error("byte count not loaded");
  AST_RESERVED_ZERO: assert property (sprWrEn |=> (excRdData & ~EXC_IMPL_MASK) == '0)
    else $error("reserved bits hold written value");
  AST_FSC_STICKY: assert property (!fscWrEn |=>
      (($past(fscRdData) & FSC_STICKY_MASK) & ~fscRdData) == '0)
    else $error("sticky float status bit cleared without a move");
  AST_CMP_NO_WRITE: assert property (fpWrEn && fpIsCompare |-> !fpMemWrEn)
    else $error("compare wrote a float register");
  AST_SINGLE_ROUNDED: assert property (fpWrEn && fpWrSingle && !expAllOnes
      |-> fpRounded[DP_DROP-1:0] == '0)
    else $error("single result not reduced to single precision");
  AST_MOVE_COND: assert property (sMoveCond |=> condFieldValid
      ##0 condFieldOut == $past(excRdData[EXC_SO -: COND_W]))
    else $error("move to condition field returned wrong bits");
  AST_FP_RECORD: assert property (sFpRecord |=> condFieldValid
      ##0 condFieldOut == fscRdData[FSC_SUM_ANY -: COND_W])
    else $error("float record missing from condition field");
  // bypass would mask a stray write, so watch a read held across it
  AST_CMP_KEEPS: assert property (sCmpOnHeldRead |=> $stable(fpRdDataA))
    else $error("compare changed a float register");
  AST_FP_DOUBLE_KEPT: assert property (fpMemWrEn && !fpWrSingle
      && fpRdAddrA == fpWrAddr |=> fpRdDataA == $past(fpWrData))
    else $error("double result altered");
  AST_INT_WRITE: assert property (intWrEn && intRdAddrA == intWrAddr
      |=> intRdDataA == $past(intWrData))
    else $error("integer result not written");
  AST_OVF_MULDIV_DW: assert property (ovfKind == OVF_MULDIV && !ovfWordForm
      |=> overflowFlag == !$past(dwordFits))
    else $error("doubleword overflow wrong");
  AST_SPR_IMAGE: assert property (sprWrEn && !bcWrEn
      && ovfKind == OVF_NONE && cryKind == CRY_NONE |=> excRdData == ($past(sprWrData) & EXC_IMPL_MASK))
    else $error("register write not taken");
  AST_MOVE_CLEARS: assert property (sMoveCond ##0 sQuietArith
      |=> !summaryOvf && !overflowFlag && !carryFlag)
    else $error("move left flags set");
  AST_BC_HELD: assert property (!bcWrEn && !sprWrEn |=> byteCount == $past(byteCount))
    else $error("byte count changed without a load");
  AST_FSC_RESULT: assert property (fpStatusValid
      |=> (fscRdData & FSC_RESULT_MASK) == ($past(fpStatusBits) & FSC_RESULT_MASK))
    else $error("result class not recorded");
  AST_FSC_FX_SET: assert property (fpStatusValid && !fscWrEn
      && |(fpStatusBits & FSC_EXC_MASK & ~fscRdData) |=> fscRdData[FSC_SUM_ANY])
    else $error("new float exception missed the summary");
  AST_FSC_SUM_DERIVED: assert property (fscWrEn && !fpStatusValid
      |=> fscRdData[FSC_SUM_INV] == |(fscRdData & FSC_INV_MASK))
    else $error("invalid summary written directly");
  AST_COND_PULSE: assert property (condFieldValid && !movCondEn
      && !(fpStatusValid && fpRecordCond) |=> !condFieldValid)
    else $error("condition valid held too long");

endmodule : cpu_register_file

// >>> verif/exec_unit_model.sv
// execution unit arithmetic that feeds carries, products and shift status
`timescale 1ns/100ps
module exec_unit_model
  import regfile_pkg::*;
#(
  parameter int XLEN = 64
) (
  input  wire logic [XLEN-1:0]   opA,
  input  wire logic [XLEN-1:0]   opB,
  input  wire logic [5:0]        shAmt,
  output logic                   carryOutMsb,
  output logic                   carryOutNext,
  output logic      [2*XLEN-1:0] mulDivResult,
  output logic                   shiftNeg,
  output logic                   shiftLostOne
);
  logic [XLEN:0]   sumFull;
  logic [XLEN-1:0] sumLow;
  always_comb begin
    sumFull      = {1'b0, opA} + {1'b0, opB};
    // carry into the msb is the carry out of the next lower bit
    sumLow       = {1'b0, opA[XLEN-2:0]} + {1'b0, opB[XLEN-2:0]};
    carryOutMsb  = sumFull[XLEN];
    carryOutNext = sumLow[XLEN-1];
    mulDivResult = (2*XLEN)'($signed(opA)) * (2*XLEN)'($signed(opB));
    shiftNeg     = opA[XLEN-1];
    shiftLostOne = |(opA & ((XLEN'(1) << shAmt) - XLEN'(1)));
  end
endmodule : exec_unit_model

// >>> verif/tb.sv
// self-checking bench for the core register file
`timescale 1ns/100ps
module tb;
  import regfile_pkg::*;
  localparam int XLEN = 64;
  logic                ref_clk = 1'b0;
  logic                reset_n;
  logic [ADDR_W-1:0]   intRdAddrA, intRdAddrB, intWrAddr, fpRdAddrA, fpRdAddrB, fpWrAddr;
  logic [XLEN-1:0]     intRdDataA, intRdDataB, intWrData, opA, opB;
  logic [FP_W-1:0]     fpRdDataA, fpRdDataB, fpWrData;
  logic                intWrEn, fpWrEn, fpWrSingle, fpIsCompare, carryOutMsb, carryOutNext;
  logic                ovfWordForm, shiftNeg, shiftLostOne, bcWrEn, sprWrEn, movCondEn;
  logic                summaryOvf, overflowFlag, carryFlag, fpStatusValid, fpRecordCond;
  logic                fscWrEn, condFieldValid;
  ovf_kind_e           ovfKind;
  cry_kind_e           cryKind;
  logic [2*XLEN-1:0]   mulDivResult;
  logic [5:0]          shAmt;
  logic [EXC_BC_W-1:0] bcValue, byteCount;
  logic [EXC_W-1:0]    sprWrData, excRdData;
  logic [FSC_W-1:0]    fpStatusBits, fscWrMask, fscWrData, fscRdData;
  logic [COND_W-1:0]   condFieldOut;
  int                  bad_count = 0;
  int                  tests_run = 0;
  int                  cycles = 0;
  // reference model state
  logic [63:0]         intMem [NUM_REGS];
  logic [63:0]         fpMem [NUM_REGS];
  logic                mSo, mOv, mCa;
  logic [6:0]          mBc;

  always #50 ref_clk = ~ref_clk;

  exec_unit_model #(.XLEN(XLEN)) u_exec (.opA, .opB, .shAmt, .carryOutMsb, .carryOutNext,
    .mulDivResult, .shiftNeg, .shiftLostOne);

  cpu_register_file #(.XLEN(XLEN)) u_dut (.ref_clk, .reset_n, .intRdAddrA, .intRdAddrB,
    .intRdDataA, .intRdDataB, .intWrEn, .intWrAddr, .intWrData, .fpRdAddrA, .fpRdAddrB,
    .fpRdDataA, .fpRdDataB, .fpWrEn, .fpWrAddr, .fpWrData, .fpWrSingle, .fpIsCompare,
    .ovfKind, .carryOutMsb, .carryOutNext, .ovfWordForm, .mulDivResult, .cryKind, .shiftNeg,
    .shiftLostOne, .bcWrEn, .bcValue, .sprWrEn, .sprWrData, .movCondEn, .excRdData,
    .byteCount, .summaryOvf, .overflowFlag, .carryFlag, .fpStatusValid, .fpStatusBits,
    .fpRecordCond, .fscWrEn, .fscWrMask, .fscWrData, .fscRdData, .condFieldOut,
    .condFieldValid);

  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize;
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chkVal(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chkVal

  // nearest even at single precision, kept in double layout
  function automatic logic [63:0] toSingle(input logic [63:0] d);
    logic [34:0] keep;
    keep = d[63:29];
    if (d[28] && (d[27:0] != 28'h0 || keep[0]))
      keep = keep + 35'h1;
    return {keep, 29'h0};
  endfunction : toSingle

  task automatic pulse;
    @(posedge ref_clk);
    {intWrEn, fpWrEn, bcWrEn, sprWrEn, movCondEn, fpStatusValid, fscWrEn} <= '0;
    ovfKind <= OVF_NONE;
    cryKind <= CRY_NONE;
    #1;
  endtask : pulse

  // kind 0 arithmetic, 1 register move, 2 move to condition, 3 byte count load
  task automatic execOp(input int kind, input logic [1:0] ok, input logic [1:0] ck,
                        input logic wf, input logic [63:0] a, input logic [63:0] b,
                        input logic [31:0] d);
    logic [64:0]  sum;
    logic [127:0] prod;
    logic         fit;
    logic [2:0]   expCond;
    sum = {1'b0, a} + {1'b0, b};
    prod = 128'($signed(a)) * 128'($signed(b));
    fit = wf ? (&prod[127:31] || ~|prod[127:31]) : (&prod[127:63] || ~|prod[127:63]);
    expCond = {mSo, mOv, mCa};
    @(posedge ref_clk);
    opA <= a;
    opB <= b;
    shAmt <= d[5:0];
    ovfWordForm <= wf;
    sprWrData <= d;
    bcValue <= d[6:0];
    if (kind == 0) begin
      ovfKind <= ovf_kind_e'(ok);
      cryKind <= cry_kind_e'(ck);
      if (ok == 2'd1)
        mOv = (a[63] == b[63]) && (sum[63] != a[63]);
      if (ok == 2'd2)
        mOv = !fit;
      if (ok == 2'd1 || ok == 2'd2)
        mSo = mSo | mOv;
      if (ck == 2'd1)
        mCa = sum[64];
      if (ck == 2'd2)
        mCa = a[63] && (((a >> d[5:0]) << d[5:0]) != a);
    end
    if (kind == 1) begin
      sprWrEn <= 1'b1;
      {mSo, mOv, mCa, mBc} = {d[31:29], d[6:0]};
    end
    if (kind == 2) begin
      movCondEn <= 1'b1;
      {mSo, mOv, mCa} = 3'b000;
    end
    if (kind == 3) begin
      bcWrEn <= 1'b1;
      mBc = d[6:0];
    end
    pulse();
    chkVal("exc", 64'({mSo, mOv, mCa, 22'h0, mBc}), 64'(excRdData));
    chkVal("views", 64'({mSo, mOv, mCa, mBc}),
           64'({summaryOvf, overflowFlag, carryFlag, byteCount}));
    chkVal("condValid", 64'(kind == 2), 64'(condFieldValid));
    if (kind == 2)
      chkVal("cond", 64'(expCond), 64'(condFieldOut[3:1]));
  endtask : execOp

  task automatic fscOp(input logic v, input logic [31:0] bits, input logic w,
                       input logic [31:0] m, input logic [31:0] expFsc);
    @(posedge ref_clk);
    fpStatusValid <= v;
    fpRecordCond <= v;
    fpStatusBits <= bits;
    fscWrEn <= w;
    fscWrMask <= m;
    fscWrData <= bits;
    pulse();
    chkVal("fsc", 64'(expFsc), 64'(fscRdData));
    chkVal("fscCondValid", 64'(v), 64'(condFieldValid));
    if (v)
      chkVal("fscCond", 64'(expFsc[31:28]), 64'(condFieldOut));
  endtask : fscOp

  initial begin
    logic [63:0] wd, fd, a, b, expA, expB, expFa, expFb;
    logic        sg, cmp, wrOn;
    int          r, k;
    reset_n = 1'b0;
    {intRdAddrA, intRdAddrB, intWrAddr, fpRdAddrA, fpRdAddrB, fpWrAddr, intWrData, opA, opB,
     fpWrData, intWrEn, fpWrEn, fpWrSingle, fpIsCompare, ovfWordForm, bcWrEn, sprWrEn,
     movCondEn, fpStatusValid, fpRecordCond, fscWrEn, shAmt, bcValue, sprWrData,
     fpStatusBits, fscWrMask, fscWrData} = '0;
    ovfKind = OVF_NONE;
    cryKind = CRY_NONE;
    foreach (intMem[i]) begin
      intMem[i] = '0;
      fpMem[i] = '0;
    end
    {mSo, mOv, mCa, mBc} = '0;
    {expA, expB, expFa, expFb} = '0;
    void'($urandom(46));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    // writes back to back with same-edge bypass, then a full read back
    for (int i = 0; i <= 2 * NUM_REGS; i++) begin
      @(posedge ref_clk);
      r = i % NUM_REGS;
      wrOn = i < NUM_REGS;
      wd = {$urandom, $urandom};
      fd = {$urandom, $urandom};
      sg = 1'($urandom);
      cmp = 1'($urandom);
      // single results kept inside the single exponent range
      if (sg)
        fd[62:52] = 11'h3ff;
      intWrEn <= wrOn;
      fpWrEn <= wrOn;
      {intWrAddr, intRdAddrA, fpWrAddr, fpRdAddrA} <= {4{5'(r)}};
      {intRdAddrB, fpRdAddrB} <= {2{5'(r - 1)}};
      intWrData <= wd;
      fpWrData <= fd;
      fpWrSingle <= sg;
      fpIsCompare <= cmp;
      #1;
      if (i > 0) begin
        chkVal("intA", expA, intRdDataA);
        chkVal("intB", expB, intRdDataB);
        chkVal("fpA", expFa, fpRdDataA);
        chkVal("fpB", expFb, fpRdDataB);
      end
      if (wrOn) begin
        intMem[r] = wd;
        if (!cmp)
          fpMem[r] = sg ? toSingle(fd) : fd;
      end
      expA = intMem[r];
      expB = intMem[(r + NUM_REGS - 1) % NUM_REGS];
      expFa = fpMem[r];
      expFb = fpMem[(r + NUM_REGS - 1) % NUM_REGS];
    end
    // a compare aimed at the register being read must leave it alone
    @(posedge ref_clk);
    {fpWrEn, fpIsCompare, fpWrSingle} <= 3'b110;
    fpWrData <= ~fpMem[0];
    @(posedge ref_clk);
    fpWrEn <= 1'b0;
    @(posedge ref_clk);
    #1;
    chkVal("fpCmp", fpMem[0], fpRdDataA);
    execOp(0, 2'd1, 2'd0, 1'b0, 64'h7fffffffffffffff, 64'h1, 32'h0);
    execOp(1, 2'd0, 2'd0, 1'b0, 64'h0, 64'h0, 32'h5fffff80);
    execOp(0, 2'd3, 2'd3, 1'b0, 64'hffffffffffffffff, 64'h1, 32'h0);
    repeat (200) begin
      k = $urandom % 8;
      a = {$urandom, $urandom};
      b = {$urandom, $urandom};
      a = $signed(a) >>> ($urandom % 64);
      b = $signed(b) >>> ($urandom % 64);
      execOp(k > 3 ? 0 : k, 2'($urandom), 2'($urandom), 1'($urandom), a, b,
             $urandom);
    end
    execOp(2, 2'd0, 2'd0, 1'b0, 64'h0, 64'h0, 32'h0);
    fscOp(1'b1, 32'h10000800, 1'b0, 32'h0, 32'h90000800);
    fscOp(1'b1, 32'h0, 1'b0, 32'h0, 32'h90000000);
    fscOp(1'b0, 32'h0, 1'b1, 32'h90000000, 32'h0);
    fscOp(1'b0, 32'h7f800040, 1'b1, 32'hffffffff, 32'h7f800040);
    fscOp(1'b1, 32'h0, 1'b0, 32'h0, 32'h7f800040);
    // a reset in mid-run clears everything, arrays included
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chkVal("rstExc", 64'h0, 64'(excRdData));
    chkVal("rstFsc", 64'h0, 64'(fscRdData));
    chkVal("rstInt", 64'h0, intRdDataA);
    chkVal("rstFp", 64'h0, fpRdDataA);
    summarize();
  end
endmodule : tb
